/* include/parallel_port_pkg.sv */
package parallel_port_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] mode_off = 12'h000;
  localparam logic [11:0] data_off = 12'h004;
  localparam logic [11:0] addr_off = 12'h008;
  localparam logic [11:0] stat_off = 12'h00c;
  localparam logic [11:0] clr_off = 12'h010;
  localparam logic [11:0] en_off = 12'h014;
  localparam logic [11:0] ctrl_off = 12'h018;
  localparam logic [11:0] buf_off = 12'h01c;
  localparam int busy_bit = 15;
  localparam logic [14:0] mode_reset = 15'h0000;
  localparam logic [15:0] addr_reset = 16'h0000;
  // mode register fields, bits 14:0
  typedef struct packed {
    logic [1:0] irq_sel;
    logic [1:0] step_sel;
    logic wide;
    logic [1:0] op_sel;
    logic [1:0] setup_wait;
    logic [3:0] strobe_wait;
    logic [1:0] end_wait;
  } mode_s;
  localparam logic [1:0] irq_cycle = 2'b01;
  localparam logic [1:0] irq_buf = 2'b10;
  localparam logic [1:0] step_inc = 2'b01;
  localparam logic [1:0] step_dec = 2'b10;
  localparam logic [1:0] step_buf = 2'b11;
  localparam logic [1:0] op_legacy = 2'b00;
  localparam logic [1:0] op_enh = 2'b01;
  localparam logic [1:0] op_m2 = 2'b10;
  localparam logic [1:0] op_m1 = 2'b11;
  localparam int ev_cycle = 0;
  localparam int ev_buf = 1;
  localparam int n_events = 2;
  // interrupt buffer index that raises the buffer event
  localparam logic [1:0] last_buf = 2'b11;
endpackage

/* hw/parallel_port_mode_control.sv */
`timescale 1ns/1ns
// Function
// - busy flag at mode bit 15 is high while a master transfer runs
// - interrupt select 00 gives none, 01 interrupts at each cycle end
// - select 10 interrupts on fourth buffer access or address lines equal 11
// - step select 01 adds one, 10 subtracts one, 00 keeps the address
// - step select 11 auto-advances slave buffers, only in legacy slave mode
// - width bit picks one 16-bit or one 8-bit transfer per data access
// - op select 11 runs direction line plus enable, 10 separate strobes
// - op select 01 is addressed slave, 00 legacy slave without address
// - setup wait code 00..11 gives 1..4 cycles of address and data setup
// - strobe wait zero forces setup 1, end 1 on write, end 0 on read
// - address bits 15 and 14 keep their value when used as chip selects
// - upper data lines join transfers only in 16-bit width
// - mode bits 31:16 read zero and writable fields reset to zero
module parallel_port_mode_control
  import parallel_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [15:0] port_address_lines,
  output logic [1:0] port_chip_selects,
  output logic port_read_strobe,
  output logic port_write_strobe,
  output logic port_enable_strobe,
  output logic [15:0] port_data_out,
  output logic [15:0] port_data_oe,
  input wire logic [15:0] port_data_in,
  input wire logic [1:0] slave_address_in,
  input wire logic slave_read_in,
  input wire logic slave_write_in,
  input wire logic slave_select_in
);
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_setup = 4'b0010,
    st_strobe = 4'b0100,
    st_end = 4'b1000
  } state_e;

  // next address, leaving chip-select bits alone
  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] sel,
                                            input logic [1:0] cs_en);
    logic [15:0] n;
    n = a;
    if (sel == step_inc) n = a + 16'h0001;
    else if (sel == step_dec) n = a - 16'h0001;
    if (cs_en[0]) n[14] = a[14];
    if (cs_en[1]) n[15] = a[15];
    return n;
  endfunction

  // end hold length; zero strobe wait forces fixed figures
  function automatic logic [1:0] end_len(input mode_s m, input logic rd);
    if (m.strobe_wait == 4'h0) return rd ? 2'b00 : 2'b01;
    return m.end_wait;
  endfunction

  mode_s mode_q;
  logic [15:0] addr_q, txd_q, rxd_q;
  logic [1:0] cs_en_q;
  logic [n_events-1:0] stat_q, en_q;
  logic [7:0] rbuf_q [4];
  logic [7:0] wbuf_q [4];
  logic [1:0] rptr_q, wptr_q;
  state_e state_q;
  logic [3:0] cnt_q;
  logic rd_q, done_q, slv_done_q, slv_last_q;
  logic [31:0] rdata_d;
  logic acc, wr_acc, rd_acc, master, start, err_d;

  // one wait state keeps pready and prdata flop-driven
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign master = mode_q.op_sel[1];
  assign start = acc && paddr == data_off && master && state_q == st_idle;

  // synchronisers for every pin coming from the far side
  logic [20:0] sy1_q, sy2_q;
  logic sy3_rd_q, sy3_wr_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_rd_q <= 1'b0;
      sy3_wr_q <= 1'b0;
    end
    else
    begin
      sy1_q <= {slave_select_in, slave_write_in, slave_read_in, slave_address_in, port_data_in};
      sy2_q <= sy1_q;
      sy3_rd_q <= sy2_q[18] & sy2_q[20];
      sy3_wr_q <= sy2_q[19] & sy2_q[20];
    end
  end
  logic [15:0] din_s;
  logic [1:0] sadr_s;
  logic s_rd, s_wr, rd_end, wr_end, bufd;
  logic [1:0] sidx_rd, sidx_wr;
  assign din_s = sy2_q[15:0];
  assign sadr_s = sy2_q[17:16];
  assign s_rd = sy2_q[18] & sy2_q[20];
  assign s_wr = sy2_q[19] & sy2_q[20];
  assign rd_end = ~master & sy3_rd_q & ~s_rd;
  assign wr_end = ~master & sy3_wr_q & ~s_wr;
  assign bufd = mode_q.step_sel == step_buf && mode_q.op_sel == op_legacy;
  assign sidx_rd = bufd ? rptr_q : (mode_q.op_sel == op_enh ? sadr_s : 2'b00);
  assign sidx_wr = bufd ? wptr_q : (mode_q.op_sel == op_enh ? sadr_s : 2'b00);

  // apb answer and register read mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == mode_off) rdata_d = {16'h0000, state_q != st_idle, mode_q};
    else if (paddr == data_off) rdata_d = {16'h0000, rxd_q};
    else if (paddr == addr_off) rdata_d = {16'h0000, addr_q};
    else if (paddr == stat_off) rdata_d = {30'h0, stat_q};
    else if (paddr == clr_off) rdata_d = 32'h0000_0000;
    else if (paddr == en_off) rdata_d = {30'h0, en_q};
    else if (paddr == ctrl_off) rdata_d = {30'h0, cs_en_q};
    else if (paddr == buf_off) rdata_d = {24'h0, wbuf_q[addr_q[1:0]]};
    else err_d = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      prdata <= rdata_d;
      pslverr <= psel & penable & ~pready & err_d;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= mode_reset;
      cs_en_q <= 2'b00;
      en_q <= '0;
      txd_q <= 16'h0000;
    end
    else if (wr_acc)
    begin
      if (paddr == mode_off) mode_q <= pwdata[14:0];
      if (paddr == ctrl_off) cs_en_q <= pwdata[1:0];
      if (paddr == en_off) en_q <= pwdata[n_events-1:0];
      if (start) txd_q <= mode_q.wide ? pwdata[15:0] : {8'h00, pwdata[7:0]};
    end
  end

  // address register, stepped once per finished master cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) addr_q <= addr_reset;
    else if (wr_acc && paddr == addr_off) addr_q <= pwdata[15:0];
    else if (done_q) addr_q <= step_addr(addr_q, mode_q.step_sel, cs_en_q);
  end

  // master sequencer: setup, strobe, end hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rxd_q <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        st_idle:
          if (start)
          begin
            state_q <= st_setup;
            rd_q <= ~pwrite;
            cnt_q <= (mode_q.strobe_wait == 4'h0) ? 4'h0 : {2'b00, mode_q.setup_wait};
          end
        st_setup:
          if (cnt_q == 4'h0)
          begin
            state_q <= st_strobe;
            cnt_q <= mode_q.strobe_wait;
          end
          else cnt_q <= cnt_q - 4'h1;
        st_strobe:
          if (cnt_q == 4'h0)
          begin
            if (rd_q) rxd_q <= mode_q.wide ? din_s : {8'h00, din_s[7:0]};
            if (end_len(mode_q, rd_q) == 2'b00)
            begin
              state_q <= st_idle;
              done_q <= 1'b1;
            end
            else
            begin
              state_q <= st_end;
              cnt_q <= {2'b00, end_len(mode_q, rd_q) - 2'b01};
            end
          end
          else cnt_q <= cnt_q - 4'h1;
        st_end:
          if (cnt_q == 4'h0)
          begin
            state_q <= st_idle;
            done_q <= 1'b1;
          end
          else cnt_q <= cnt_q - 4'h1;
        default: state_q <= st_idle;
      endcase
    end
  end

  // slave buffers; host reads rbuf and writes wbuf
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rbuf_q[i] <= 8'h00;
        wbuf_q[i] <= 8'h00;
      end
      rptr_q <= 2'b00;
      wptr_q <= 2'b00;
      slv_done_q <= 1'b0;
      slv_last_q <= 1'b0;
    end
    else
    begin
      slv_done_q <= rd_end | wr_end;
      slv_last_q <= (rd_end && sidx_rd == last_buf) || (wr_end && sidx_wr == last_buf);
      if (wr_acc && paddr == buf_off) rbuf_q[addr_q[1:0]] <= pwdata[7:0];
      if (wr_end) wbuf_q[sidx_wr] <= din_s[7:0];
      if (rd_end && bufd) rptr_q <= rptr_q + 2'b01;
      if (wr_end && bufd) wptr_q <= wptr_q + 2'b01;
    end
  end

  // sticky events; a set in the clearing cycle wins
  logic [n_events-1:0] ev;
  logic sel_last;
  assign sel_last = bufd || mode_q.op_sel == op_enh;
  assign ev[ev_cycle] = mode_q.irq_sel == irq_cycle && (done_q || slv_done_q);
  assign ev[ev_buf] = mode_q.irq_sel == irq_buf && slv_last_q && sel_last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == clr_off) stat_q <= (stat_q & ~pwdata[n_events-1:0]) | ev;
      else stat_q <= stat_q | ev;
      irq <= |(stat_q & en_q);
    end
  end

  // pin drivers, registered from the sequencer state
  logic strobe, active;
  assign strobe = state_q == st_strobe;
  assign active = state_q != st_idle;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_address_lines <= 16'h0000;
      port_chip_selects <= 2'b00;
      port_read_strobe <= 1'b0;
      port_write_strobe <= 1'b0;
      port_enable_strobe <= 1'b0;
      port_data_out <= 16'h0000;
      port_data_oe <= 16'h0000;
    end
    else if (master)
    begin
      port_address_lines <= addr_q;
      port_chip_selects <= cs_en_q & {addr_q[15], addr_q[14]} & {2{active}};
      if (mode_q.op_sel == op_m1)
      begin
        port_read_strobe <= active & rd_q;
        port_write_strobe <= 1'b0;
        port_enable_strobe <= strobe;
      end
      else
      begin
        port_read_strobe <= strobe & rd_q;
        port_write_strobe <= strobe & ~rd_q;
        port_enable_strobe <= 1'b0;
      end
      port_data_out <= txd_q;
      port_data_oe <= (active && !rd_q) ? {{8{mode_q.wide}}, 8'hff} : 16'h0000;
    end
    else
    begin
      // slave: only the low byte, driven while the host reads
      port_address_lines <= 16'h0000;
      port_chip_selects <= 2'b00;
      port_read_strobe <= 1'b0;
      port_write_strobe <= 1'b0;
      port_enable_strobe <= 1'b0;
      port_data_out <= {8'h00, rbuf_q[sidx_rd]};
      port_data_oe <= s_rd ? 16'h00ff : 16'h0000;
    end
  end

  // busy as read back must match the sequencer state at the latching edge
  a_busy_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == mode_off |-> prdata[busy_bit] == ($past(state_q) != st_idle))
    else $error("busy flag differs from sequencer state");
  // with events off, a clear may drop bits but nothing may set one
  a_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.irq_sel == 2'b00 |=> (stat_q & ~$past(stat_q)) == 2'b00)
    else $error("event with interrupt select off");
  a_cycle_irq: assert property (@(posedge pclk) disable iff (!presetn)
    done_q && mode_q.irq_sel == irq_cycle |=> stat_q[ev_cycle])
    else $error("cycle end event lost");
  a_buf_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ev[ev_buf] |=> stat_q[ev_buf])
    else $error("buffer event lost");
  a_step_inc: assert property (@(posedge pclk) disable iff (!presetn)
    done_q && mode_q.step_sel == step_inc && cs_en_q == 2'b00 |=>
    addr_q == $past(addr_q) + 16'h0001)
    else $error("address not incremented");
  a_cs_hold: assert property (@(posedge pclk) disable iff (!presetn)
    done_q && cs_en_q == 2'b11 |=> addr_q[15:14] == $past(addr_q[15:14]))
    else $error("chip select bits stepped");
  a_fast_read: assert property (@(posedge pclk) disable iff (!presetn)
    start && !pwrite && mode_q.strobe_wait == 4'h0 |=> ##2 done_q)
    else $error("zero wait read length wrong");
  a_fast_write: assert property (@(posedge pclk) disable iff (!presetn)
    start && pwrite && mode_q.strobe_wait == 4'h0 |=> ##3 done_q)
    else $error("zero wait write length wrong");
  a_setup_len: assert property (@(posedge pclk) disable iff (!presetn)
    start && mode_q.strobe_wait != 4'h0 && mode_q.setup_wait == 2'b11 |=>
    state_q == st_setup [*4] ##1 strobe)
    else $error("setup wait length wrong");
  a_upper_lines: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_q.wide && $stable(mode_q) |=> port_data_oe[15:8] == 8'h00)
    else $error("upper lines driven in 8-bit mode");
  a_hi_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == mode_off |-> prdata[31:16] == 16'h0000)
    else $error("mode upper bits not zero");
  c_master_wr: cover property (@(posedge pclk) disable iff (!presetn) start && pwrite ##[1:40] done_q);
  c_slave_buf: cover property (@(posedge pclk) disable iff (!presetn) ev[ev_buf]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

/* verif/port_partner.sv */
`timescale 1ns/1ns
module port_partner
(
  input wire logic pclk,
  input wire logic port_read_strobe,
  input wire logic [15:0] port_data_out,
  input wire logic [15:0] port_data_oe,
  input wire logic [15:0] answer_data,
  output logic [15:0] port_data_in,
  output logic [1:0] slave_address_in,
  output logic slave_read_in,
  output logic slave_write_in,
  output logic slave_select_in
);
  logic [15:0] drive_q = 16'h0000;
  logic [15:0] host_data = 16'h0000;
  logic host_drive = 1'b0;

  initial
  begin
    slave_address_in = 2'h0;
    slave_read_in = 1'b0;
    slave_write_in = 1'b0;
    slave_select_in = 1'b0;
  end

  // answer a master read one cycle late, like a slow peripheral; a released bus toggles
  always @(posedge pclk)
  begin
    if (port_read_strobe)
      drive_q <= answer_data;
    else if (host_drive)
      drive_q <= host_data;
    else
      drive_q <= ~drive_q;
  end

  // the device wins every bit whose output enable it holds
  assign port_data_in = (port_data_oe & port_data_out) | (~port_data_oe & drive_q);

  // one host access; data is held two cycles past the strobe to cover synchroniser lag
  task automatic host_access(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge pclk);
    slave_address_in <= a;
    slave_select_in <= 1'b1;
    slave_write_in <= wr;
    slave_read_in <= ~wr;
    host_data <= {8'h00, d};
    host_drive <= wr;
    repeat (6) @(posedge pclk);
    slave_select_in <= 1'b0;
    slave_write_in <= 1'b0;
    slave_read_in <= 1'b0;
    repeat (2) @(posedge pclk);
    host_drive <= 1'b0;
    slave_address_in <= ~a;
    repeat (6) @(posedge pclk);
  endtask
endmodule

/* verif/tb_parallel_port_mode_control.sv */
`timescale 1ns/1ns
module tb_parallel_port_mode_control;
  import parallel_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, mw;
  logic pready, pslverr, irq, err, busy, w, wide, en;
  logic [15:0] pal, pdo, poe, pdi, answer, oe_seen, dout_seen, a, d, eoe, adr_seen, sl_dat;
  logic [1:0] pcs, sa, isel, st, op, cs, cs_seen;
  logic prs, pws, pes, sr, sw, ss;
  logic [3:0] stw;
  int error_cnt = 0, n_compared = 0, wcnt, rcnt, ecnt;

  parallel_port_mode_control i_parallel_port_mode_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_address_lines(pal), .port_chip_selects(pcs), .port_read_strobe(prs),
    .port_write_strobe(pws), .port_enable_strobe(pes), .port_data_out(pdo),
    .port_data_oe(poe), .port_data_in(pdi), .slave_address_in(sa), .slave_read_in(sr),
    .slave_write_in(sw), .slave_select_in(ss));
  port_partner i_port_partner (.pclk(pclk), .port_read_strobe(prs), .port_data_out(pdo),
    .port_data_oe(poe), .answer_data(answer), .port_data_in(pdi), .slave_address_in(sa),
    .slave_read_in(sr), .slave_write_in(sw), .slave_select_in(ss));

  always #5 pclk = ~pclk;

  // pin activity of the running transfer, gathered for the checks after it
  // sampled mid-cycle, where the registered pins have settled
  always @(negedge pclk)
  begin
    wcnt += int'(pws);
    rcnt += int'(prs);
    ecnt += int'(pes);
    oe_seen |= poe;
    cs_seen |= pcs;
    if (pws | pes)
      dout_seen = pdo & poe;
    if (pws | pes | prs)
      adr_seen = pal;
    if (poe != 16'h0000)
      sl_dat = pdo & poe;
  end

  task automatic results;
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // no wait is assumed: the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    // release only after the edge at which pready is taken
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    int n = 0;
    do
    begin
      apb(1'b0, mode_off, 32'h0);
      n++;
    end
    while (rd[busy_bit] !== 1'b0 && n < 40);
    chk("busy clear", 32'h0, {31'h0, rd[busy_bit]});
    repeat (4) @(posedge pclk);
  endtask

  // address after one cycle; chip-select bits keep their value
  function automatic logic [15:0] next_addr(logic [15:0] x, logic [1:0] s, logic [1:0] c);
    logic [15:0] n;
    n = (s == step_inc) ? x + 16'h0001 : (s == step_dec) ? x - 16'h0001 : x;
    if (c[0])
      n[14] = x[14];
    if (c[1])
      n[15] = x[15];
    return n;
  endfunction

  initial
  begin
    void'($urandom(14));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mode_off, 32'h0);
    chk("mode reset", 32'h0, rd);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    for (int i = 0; i < 15; i++)
    begin
      w = (i % 3 != 2);
      op = {1'b1, 1'($urandom_range(0, 1))};
      isel = 2'($urandom_range(0, 1));
      st = 2'($urandom_range(0, 2));
      wide = 1'($urandom_range(0, 1));
      stw = w ? 4'($urandom_range(0, 15)) : 4'($urandom_range(5, 15));
      if (i < 2 || i == 14)
        stw = 4'h0;
      cs = (i % 2 == 1) ? 2'b11 : 2'b00;
      a = (i < 4) ? {16{i[1]}} : 16'($urandom);
      d = 16'($urandom);
      en = 1'($urandom_range(0, 1));
      answer <= d;
      mw = {17'h0, isel, st, wide, op, 2'($urandom_range(0, 3)), stw, 2'($urandom_range(0, 3))};
      apb(1'b1, mode_off, mw | 32'hffff_0000);
      apb(1'b1, ctrl_off, {30'h0, cs});
      apb(1'b1, addr_off, {16'h0, a});
      apb(1'b1, en_off, {31'h0, en});
      apb(1'b1, clr_off, 32'h3);
      apb(1'b0, mode_off, 32'h0);
      chk("mode", mw, rd);
      wcnt = 0;
      rcnt = 0;
      ecnt = 0;
      oe_seen = 16'h0;
      cs_seen = 2'b00;
      apb(w, data_off, {16'h0, d});
      apb(1'b0, mode_off, 32'h0);
      busy = rd[busy_bit];
      wait_idle();
      if (stw > 4'h3)
        chk("busy", 32'h1, {31'h0, busy});
      chk("strobes", (op == op_m1) ? 32'(stw) + 1 : (32'(stw) + 1) << (w ? 16 : 8),
        {8'h0, wcnt[7:0], (op == op_m1) ? 8'h0 : rcnt[7:0], ecnt[7:0]});
      eoe = w ? (wide ? 16'hffff : 16'h00ff) : 16'h0000;
      chk("oe", {16'h0, eoe}, {16'h0, oe_seen});
      if (w)
        chk("dout", {16'h0, d & eoe}, {16'h0, dout_seen});
      chk("addr pins", {16'h0, a}, {16'h0, adr_seen});
      chk("chip selects", {30'h0, cs & {a[15], a[14]}}, {30'h0, cs_seen});
      apb(1'b0, addr_off, 32'h0);
      chk("addr", {16'h0, next_addr(a, st, cs)}, rd);
      apb(1'b0, stat_off, 32'h0);
      chk("status", {31'h0, isel == irq_cycle}, rd);
      chk("irq", {31'h0, isel == irq_cycle && en}, {31'h0, irq});
      if (!w)
      begin
        apb(1'b0, data_off, 32'h0);
        // a zero-wait read is too short for the slow partner to answer
        if (stw != 4'h0)
          chk("rdata", {16'h0, wide ? d : {8'h00, d[7:0]}}, rd);
        wait_idle();
      end
    end
    // addressed slave: only an access at address 3 raises the buffer event
    apb(1'b1, clr_off, 32'h3);
    apb(1'b1, en_off, 32'h3);
    apb(1'b1, mode_off, {17'h0, irq_buf, 2'b00, 1'b0, op_enh, 8'h00});
    i_port_partner.host_access(1'b1, 2'b01, 8'h5a);
    apb(1'b0, stat_off, 32'h0);
    chk("slave addr 1", 32'h0, rd);
    i_port_partner.host_access(1'b1, 2'b11, 8'hc3);
    apb(1'b0, stat_off, 32'h0);
    chk("slave addr 3", 32'h2, rd);
    chk("slave irq", 32'h1, {31'h0, irq});
    apb(1'b1, addr_off, 32'h3);
    apb(1'b0, buf_off, 32'h0);
    chk("slave buf", 32'hc3, rd);
    // host read of a software-loaded byte raises the cycle-end event
    apb(1'b1, addr_off, 32'h2);
    apb(1'b1, buf_off, 32'h3c);
    apb(1'b1, mode_off, {17'h0, irq_cycle, 2'b00, 1'b0, op_enh, 8'h00});
    apb(1'b1, clr_off, 32'h3);
    i_port_partner.host_access(1'b0, 2'b10, 8'h00);
    apb(1'b0, stat_off, 32'h0);
    chk("slave read event", 32'h1, rd);
    chk("slave rdata", 32'h3c, {16'h0, sl_dat});
    // buffered legacy slave: the fourth buffer write raises the event
    apb(1'b1, clr_off, 32'h3);
    apb(1'b1, mode_off, {17'h0, irq_buf, step_buf, 1'b0, op_legacy, 8'h00});
    for (int k = 0; k < 4; k++)
    begin
      i_port_partner.host_access(1'b1, 2'(k), 8'(k + 1));
      apb(1'b0, stat_off, 32'h0);
      chk("buffered", (k == 3) ? 32'h2 : 32'h0, rd);
    end
    results();
  end

  // hang guard, well past the expected length of all tests
  initial
  begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    results();
  end
endmodule
